// File: rtl/fb_exec_consts.svh
// Constants for the ladder function-block execution unit
`ifndef FB_EXEC_CONSTS_SVH
`define FB_EXEC_CONSTS_SVH
`define CLK_PERIOD_NS 20
`define MS_TIME_NS 1000000
`define NUM_LIMIT 8'h7f
`define TICK_MS_SEL0 32'h0000_0008
`define TICK_MS_SEL1 32'h0000_0030
`define TICK_MS_SEL2 32'h0000_03e8
`define TICK_MS_SEL3 32'h0000_2710
`define TICK_MS_SEL4 32'h0000_ea60
`define TICK_MS_SEL5 32'h0000_0001
`define DEC_LEN_BYTE 16'h0001
`define DEC_LEN_WORD 16'h0002
`define DEC_SPAN_BYTE 16'h0008
`define DEC_SPAN_WORD 16'h0010
`define COD_WIDTH_WORD 16'h0002
`define COD_MAX_ENTRIES 7'h64
`define COD_TABLE_BYTES 11'h200
`endif

// File: rtl/fb_exec_pkg.sv
// Types shared by the ladder function-block execution unit
`default_nettype none
package fb_exec_pkg;
  typedef enum logic [3:0] {
    OP_TMR_BASE, OP_TMR_VAR, OP_CTR, OP_DEC, OP_COD,
    OP_GATE, OP_GATE_END, OP_ROT, OP_FLOW, OP_OTHER
  } fb_op_t;

  typedef struct packed {
    logic [15:0] div;
    logic [31:0] ms_now;
    logic [31:0] scan_mark;
    logic [31:0] delta;
    logic [127:0][31:0] tmr_acc;
    logic [127:0][15:0] ctr_val;
    logic [127:0] ctr_coil;
    logic [127:0] ctr_prev;
    logic [127:0] cod_err;
    logic [127:0] tmr_seen;
    logic [127:0] ctr_seen;
    logic check_arm;
    logic checking;
    logic in_gate;
    logic gate_off;
    logic alarm;
    logic [511:0][7:0] table_mem;
    logic [15:0] rot_data;
    logic rot_dir;
    logic res_valid;
    logic res_coil;
    logic [15:0] res_data;
  } fb_state_t;
endpackage
`default_nettype wire

// File: rtl/fb_exec.sv
// Ladder function-block execution unit: timers, counter, decoder, converter, gate, indexer
//
// Summary of operation
// - Delay timer runs while condition is 1, clears at 0; coil 1 once preset reached.
// - Delay timer instances are numbered 0 to 127.
// - Both timer kinds share numbers; repeats or out-of-range numbers raise the alarm in the first scan after a load.
// - Counter initial value is 0 or 1 per first-number select.
// - Counter counts down when direction is 1, up when 0.
// - Counter reset forces coil 0 and count to initial value.
// - Counter steps only on condition rising edge; otherwise count and coil hold.
// - Counter numbers 0 to 127; repeats or out-of-range raise the alarm in the first scan after a load.
// - Ring counter sets coil at preset counting up (at initial value counting down); next count wraps to the other end.
// - Loading a new program clears every counter value.
// - Decoder sets the one bit matching code minus base; condition 0 clears all.
// - Length 0001 means byte code, 8-bit result; 0002 means word, 16-bit result.
// - Converter uses byte index into its table and outputs the entry when enabled.
// - Converter coil goes 1 on failure; its reset input clears it unless a failure comes in the same cycle.
// - A table holds at most 100 entries; all tables fit in 512 bytes.
// - Gate condition 0 forces coils up to its end marker to 0.
// - Missing end, nested gate or flow codes inside a gate raise the alarm.
// - Indexer positions start at 0 or 1 per first-number select.
// - Shortest-path select 0 always forward; 1 picks the shorter direction.
// - Preceding select aims at target itself or the position just before it.
// - Indexer outputs position or step count; condition 0 leaves outputs unchanged.
// - Indexer coil is 0 for forward, 1 for reverse.
`timescale 1ns/1ps
`default_nettype none
`include "fb_exec_consts.svh"

module fb_exec #(
  parameter int MS_CYCLES = `MS_TIME_NS / `CLK_PERIOD_NS
) (
  input wire logic core_clk, // 50 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic prog_load, // Pulse: new ladder program loaded
  input wire logic scan_start, // Pulse: a ladder scan begins
  input wire logic op_valid, // Pulse: evaluate one block
  input wire fb_exec_pkg::fb_op_t op_code, // Block kind
  input wire logic [7:0] op_num, // Timer/counter/converter instance number
  input wire logic execute_condition, // Block execution condition
  input wire logic op_reset, // Counter/converter reset input
  input wire logic first_number_select, // Initial value / first position 0 or 1
  input wire logic count_direction, // Counter: 1 down, 0 up
  input wire logic ring_mode, // Counter ring operation
  input wire logic short_path, // Indexer shortest-path select
  input wire logic preceding_pos, // Indexer aims before target
  input wire logic step_output, // Indexer outputs steps instead of position
  input wire logic [2:0] tick_select, // Variant timer resolution
  input wire logic [15:0] op_len, // Decoder length / converter entry width
  input wire logic [15:0] first_operand, // Preset, code, index or position count
  input wire logic [15:0] second_operand, // Decode base, table offset or current pos
  input wire logic [15:0] goal_operand, // Table capacity or target position
  input wire logic tbl_we, // Conversion table byte write
  input wire logic [8:0] tbl_addr, // Conversion table byte address
  input wire logic [7:0] tbl_wdata, // Conversion table byte data
  output logic res_valid, // Pulse: result of the last block
  output logic res_coil, // Block result coil
  output logic [15:0] res_data, // Block outcome operand
  output logic alarm // Sticky program alarm until next load
);
  import fb_exec_pkg::*;

  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  fb_state_t st_r, st_nxt;

  function automatic logic [31:0] tick_ms(input logic [2:0] sel);
    case (sel)
      3'h1: tick_ms = `TICK_MS_SEL1;
      3'h2: tick_ms = `TICK_MS_SEL2;
      3'h3: tick_ms = `TICK_MS_SEL3;
      3'h4: tick_ms = `TICK_MS_SEL4;
      3'h5: tick_ms = `TICK_MS_SEL5;
      default: tick_ms = `TICK_MS_SEL0;
    endcase
  endfunction

  // Distance from b to a going forward round a ring of n positions
  function automatic logic [7:0] ring_diff(input logic [7:0] a, input logic [7:0] b,
                                           input logic [7:0] n);
    logic [8:0] t;
    t = (a >= b) ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, n} - {1'b0, b};
    ring_diff = t[7:0];
  endfunction

  logic [6:0] idx;
  logic num_bad;
  logic [32:0] acc_sum;
  logic [31:0] acc_new;
  logic [47:0] acc_limit;
  logic [15:0] ctr_init, ctr_cur, ctr_new;
  logic dec_word;
  logic [15:0] dec_code, dec_off;
  logic cod_word, cod_fail;
  logic [10:0] cod_a, cod_end;
  logic [7:0] rot_n, rot_cur, rot_tgt, rot_f, rot_r, rot_steps, rot_pos;
  logic rot_rev;
  logic coil, gated;
  logic [15:0] data;

  always_comb begin
    st_nxt = st_r;
    st_nxt.res_valid = 1'b0;
    idx = op_num[6:0];
    num_bad = op_num > `NUM_LIMIT;
    acc_sum = {1'b0, st_r.tmr_acc[idx]} + {1'b0, st_r.delta};
    acc_new = acc_sum[32] ? 32'hffff_ffff : acc_sum[31:0];
    acc_limit = 48'(first_operand) *
                48'(tick_ms((op_code == OP_TMR_BASE) ? 3'h0 : tick_select));
    ctr_init = {15'h0, first_number_select};
    ctr_cur = st_r.ctr_val[idx];
    ctr_new = ctr_cur;
    dec_word = op_len == `DEC_LEN_WORD;
    dec_code = dec_word ? first_operand : {8'h0, first_operand[7:0]};
    dec_off = dec_code - second_operand;
    cod_word = op_len == `COD_WIDTH_WORD;
    cod_a = {2'h0, second_operand[8:0]} +
            (cod_word ? {2'h0, first_operand[7:0], 1'b0} : {3'h0, first_operand[7:0]});
    cod_end = {2'h0, second_operand[8:0]} +
              (cod_word ? {3'h0, goal_operand[6:0], 1'b0} : {4'h0, goal_operand[6:0]});
    cod_fail = (goal_operand[15:7] != 9'h0) || (goal_operand[6:0] > `COD_MAX_ENTRIES) ||
               ({8'h0, first_operand[7:0]} >= goal_operand) ||
               (cod_end > `COD_TABLE_BYTES);
    rot_n = first_operand[7:0];
    rot_cur = second_operand[7:0] - {7'h0, first_number_select};
    rot_tgt = goal_operand[7:0] - {7'h0, first_number_select};
    rot_f = ring_diff(rot_tgt, rot_cur, rot_n);
    rot_r = ring_diff(rot_cur, rot_tgt, rot_n);
    rot_rev = short_path && (rot_r < rot_f);
    rot_steps = rot_rev ? rot_r : rot_f;
    rot_pos = rot_tgt;
    coil = 1'b0;
    gated = 1'b0;
    data = st_r.res_data;

    // Millisecond base shared by every timer
    if (st_r.div == MS_LAST) begin
      st_nxt.div = 16'h0;
      st_nxt.ms_now = st_r.ms_now + 32'h1;
    end else begin
      st_nxt.div = st_r.div + 16'h1;
    end

    // Time accrued since the previous scan, applied to each running timer once
    if (scan_start) begin
      st_nxt.delta = st_r.ms_now - st_r.scan_mark;
      st_nxt.scan_mark = st_r.ms_now;
      st_nxt.checking = st_r.check_arm;
      st_nxt.check_arm = 1'b0;
      if (st_r.in_gate) begin
        st_nxt.alarm = 1'b1;
      end
      st_nxt.in_gate = 1'b0;
    end

    if (tbl_we) begin
      st_nxt.table_mem[tbl_addr] = tbl_wdata;
    end

    // A load in the same cycle as a block request drops the request
    if (prog_load) begin
      st_nxt.ctr_val = '0;
      st_nxt.ctr_coil = '0;
      st_nxt.ctr_prev = '0;
      st_nxt.tmr_acc = '0;
      st_nxt.cod_err = '0;
      st_nxt.tmr_seen = '0;
      st_nxt.ctr_seen = '0;
      st_nxt.alarm = 1'b0;
      st_nxt.check_arm = 1'b1;
      st_nxt.checking = 1'b0;
      st_nxt.in_gate = 1'b0;
    end else if (op_valid) begin
      unique case (op_code)
        OP_TMR_BASE, OP_TMR_VAR: begin
          // Number check runs during the first scan after a load only
          if (st_r.checking && (num_bad || st_r.tmr_seen[idx])) begin
            st_nxt.alarm = 1'b1;
          end
          if (st_r.checking) begin
            st_nxt.tmr_seen[idx] = 1'b1;
          end
          if (!num_bad) begin
            st_nxt.tmr_acc[idx] = execute_condition ? acc_new : 32'h0;
            coil = execute_condition && ({16'h0, acc_new} >= acc_limit);
            data = execute_condition ? acc_new[15:0] : 16'h0;
          end
        end
        OP_CTR: begin
          if (st_r.checking && (num_bad || st_r.ctr_seen[idx])) begin
            st_nxt.alarm = 1'b1;
          end
          if (st_r.checking) begin
            st_nxt.ctr_seen[idx] = 1'b1;
          end
          if (!num_bad) begin
            if (op_reset) begin
              st_nxt.ctr_val[idx] = ctr_init;
              st_nxt.ctr_coil[idx] = 1'b0;
            end else if (execute_condition && !st_r.ctr_prev[idx]) begin
              if (!count_direction) begin
                if (ctr_cur >= first_operand) begin
                  ctr_new = ring_mode ? ctr_init : first_operand;
                end else begin
                  ctr_new = ctr_cur + 16'h1;
                end
              end else begin
                if (ctr_cur <= ctr_init) begin
                  ctr_new = ring_mode ? first_operand : ctr_init;
                end else begin
                  ctr_new = ctr_cur - 16'h1;
                end
              end
              st_nxt.ctr_val[idx] = ctr_new;
              st_nxt.ctr_coil[idx] = count_direction ? (ctr_new == ctr_init)
                                                     : (ctr_new == first_operand);
            end
            st_nxt.ctr_prev[idx] = execute_condition;
            coil = st_nxt.ctr_coil[idx];
            data = st_nxt.ctr_val[idx];
          end
        end
        OP_DEC: begin
          data = 16'h0;
          if (!dec_word && op_len != `DEC_LEN_BYTE) begin
            st_nxt.alarm = 1'b1;
          end else if (execute_condition &&
                       dec_off < (dec_word ? `DEC_SPAN_WORD : `DEC_SPAN_BYTE)) begin
            data[dec_off[3:0]] = 1'b1;
          end
        end
        OP_COD: begin
          if (!num_bad) begin
            // A failure in the same cycle as reset keeps the coil set
            if (execute_condition && cod_fail) begin
              st_nxt.cod_err[idx] = 1'b1;
            end else if (op_reset) begin
              st_nxt.cod_err[idx] = 1'b0;
            end
            if (execute_condition && !cod_fail) begin
              data = cod_word ? {st_r.table_mem[cod_a[8:0] + 9'h1], st_r.table_mem[cod_a[8:0]]}
                              : {8'h0, st_r.table_mem[cod_a[8:0]]};
            end
            coil = st_nxt.cod_err[idx];
          end
        end
        OP_GATE: begin
          if (st_r.in_gate) begin
            st_nxt.alarm = 1'b1;
          end
          st_nxt.in_gate = 1'b1;
          st_nxt.gate_off = !execute_condition;
        end
        OP_GATE_END: begin
          if (!st_r.in_gate) begin
            st_nxt.alarm = 1'b1;
          end
          st_nxt.in_gate = 1'b0;
        end
        OP_FLOW: begin
          if (st_r.in_gate) begin
            st_nxt.alarm = 1'b1;
          end
        end
        OP_ROT: begin
          if (execute_condition && rot_n != 8'h0) begin
            if (preceding_pos) begin
              if (rot_rev) begin
                rot_pos = (rot_tgt + 8'h1 == rot_n) ? 8'h0 : rot_tgt + 8'h1;
              end else begin
                rot_pos = (rot_tgt == 8'h0) ? rot_n - 8'h1 : rot_tgt - 8'h1;
              end
              rot_steps = (rot_steps == 8'h0) ? 8'h0 : rot_steps - 8'h1;
            end
            st_nxt.rot_data = step_output ? {8'h0, rot_steps}
                                          : {8'h0, rot_pos + {7'h0, first_number_select}};
            st_nxt.rot_dir = rot_rev;
          end else if (execute_condition) begin
            st_nxt.alarm = 1'b1;
          end
          data = st_nxt.rot_data;
          coil = st_nxt.rot_dir;
        end
        OP_OTHER: begin
        end
      endcase
      gated = st_r.in_gate && st_r.gate_off && op_code != OP_GATE && op_code != OP_GATE_END;
      st_nxt.res_valid = 1'b1;
      st_nxt.res_coil = coil && !gated;
      st_nxt.res_data = data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign res_valid = st_r.res_valid;
  assign res_coil = st_r.res_coil;
  assign res_data = st_r.res_data;
  assign alarm = st_r.alarm;

  logic blk;
  assign blk = op_valid && !prog_load;

  AST_TMR_STOP: assert property (@(posedge core_clk) disable iff (!rst_n)
    blk && op_code == OP_TMR_VAR && !execute_condition |=> res_valid && !res_coil)
    else $error("timer coil set while stopped");
  AST_NUM_RANGE: assert property (@(posedge core_clk) disable iff (!rst_n)
    blk && st_r.checking && (op_code == OP_CTR || op_code == OP_TMR_VAR) && op_num > 8'h7f
    |=> alarm)
    else $error("out-of-range number not flagged");
  AST_CTR_RST: assert property (@(posedge core_clk) disable iff (!rst_n)
    blk && op_code == OP_CTR && op_reset && op_num < 8'h80 |=> !res_coil &&
    res_data == {15'h0, $past(first_number_select)})
    else $error("counter reset wrong");
  AST_LOAD_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
    prog_load |=> st_r.ctr_val == '0 && !alarm)
    else $error("load did not clear counters");
  AST_DEC_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
    blk && op_code == OP_DEC && !execute_condition |=> res_data == 16'h0)
    else $error("decoder output not cleared");
  AST_DEC_HOT: assert property (@(posedge core_clk) disable iff (!rst_n)
    blk && op_code == OP_DEC && execute_condition && op_len == 16'h0001 &&
    first_operand[7:0] == second_operand[7:0] && second_operand[15:8] == 8'h0
    |=> res_data == 16'h0001)
    else $error("decoder bit misplaced");
  AST_COD_ERR: assert property (@(posedge core_clk) disable iff (!rst_n)
    blk && op_code == OP_COD && execute_condition && op_num < 8'h80 &&
    !(st_r.in_gate && st_r.gate_off) &&
    {8'h0, first_operand[7:0]} >= goal_operand ##1 !(op_valid && op_code == OP_COD)
    |-> res_coil && st_r.cod_err[$past(op_num[6:0], 1)])
    else $error("converter error not raised");
  AST_GATE_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
    blk && st_r.in_gate && st_r.gate_off && op_code != OP_GATE && op_code != OP_GATE_END
    |=> !res_coil)
    else $error("coil not forced inside gate");
  AST_ROT_FWD: assert property (@(posedge core_clk) disable iff (!rst_n)
    blk && op_code == OP_ROT && execute_condition && !short_path &&
    first_operand[7:0] != 8'h0 |=> !res_coil)
    else $error("reverse without shortest-path select");
  AST_ROT_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    blk && op_code == OP_ROT && !execute_condition && !(st_r.in_gate && st_r.gate_off)
    |=> res_data == $past(st_r.rot_data) &&
    res_coil == $past(st_r.rot_dir) && $stable(st_r.rot_data))
    else $error("indexer outputs changed while idle");
endmodule
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the ladder function-block execution unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fb_exec_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic prog_load = 1'b0, scan_start = 1'b0, op_valid = 1'b0;
  fb_op_t op_code = OP_OTHER;
  logic [7:0] op_num = 8'h00;
  logic execute_condition = 1'b0, op_reset = 1'b0, first_number_select = 1'b0;
  logic count_direction = 1'b0, ring_mode = 1'b0, short_path = 1'b0;
  logic preceding_pos = 1'b0, step_output = 1'b0;
  logic [2:0] tick_select = 3'h0;
  logic [15:0] op_len = 16'h0001, first_operand = 16'h0000;
  logic [15:0] second_operand = 16'h0000, goal_operand = 16'h0000;
  logic tbl_we = 1'b0;
  logic [8:0] tbl_addr = 9'h000;
  logic [7:0] tbl_wdata = 8'h00;
  logic res_valid, res_coil, alarm;
  logic [15:0] res_data;
  logic [7:0] mem [0:511];
  int error_cnt = 0;
  int checks = 0;
  integer seed = 30636;
  int rg[7] = '{10, 8, 5, 3, 10, 10, 0};
  int rr[7] = '{11, 9, 4, 2, 9, 3, 11};
  int rc[7] = '{1, 1, 0, 0, 0, 1, 0};

  // Short millisecond so timer runs stay brief
  fb_exec #(.MS_CYCLES(5)) uut (.core_clk(core_clk), .rst_n(rst_n), .prog_load(prog_load),
    .scan_start(scan_start), .op_valid(op_valid), .op_code(op_code), .op_num(op_num),
    .execute_condition(execute_condition), .op_reset(op_reset),
    .first_number_select(first_number_select), .count_direction(count_direction),
    .ring_mode(ring_mode), .short_path(short_path), .preceding_pos(preceding_pos),
    .step_output(step_output), .tick_select(tick_select), .op_len(op_len),
    .first_operand(first_operand), .second_operand(second_operand),
    .goal_operand(goal_operand), .tbl_we(tbl_we), .tbl_addr(tbl_addr),
    .tbl_wdata(tbl_wdata), .res_valid(res_valid), .res_coil(res_coil),
    .res_data(res_data), .alarm(alarm));

  always #10 core_clk = ~core_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t ns: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic done(input string name);
    $display("Test %s finished, mismatches so far %0d", name, error_cnt);
  endtask

  // One op per two cycles so op_valid is never rewritten in one time step
  task automatic op(input fb_op_t c, input logic [7:0] n, input logic cond);
    op_code = c;
    op_num = n;
    execute_condition = cond;
    op_valid = 1'b1;
    @(negedge core_clk);
    op_valid = 1'b0;
    chk({15'h0000, res_valid}, 16'h0001);
    @(negedge core_clk);
  endtask

  // A scan lasts 16 cycles, just over three short milliseconds
  task automatic scan(input logic load);
    prog_load = load;
    scan_start = ~load;
    @(negedge core_clk);
    prog_load = 1'b0;
    scan_start = 1'b0;
    repeat (15) @(negedge core_clk);
  endtask

  task automatic tbl_put(input logic [8:0] a, input logic [7:0] d);
    tbl_addr = a;
    tbl_wdata = d;
    tbl_we = 1'b1;
    @(negedge core_clk);
    tbl_we = 1'b0;
    @(negedge core_clk);
  endtask

  function automatic logic [15:0] dec_exp(input logic [15:0] c, input logic [15:0] b,
                                          input logic [15:0] w);
    logic [15:0] d;
    d = c - b;
    dec_exp = (d < ((w == 16'h0001) ? 16'h0008 : 16'h0010)) ? (16'h0001 << d) : 16'h0000;
  endfunction

  task automatic count_run(input logic ring);
    int i;
    ring_mode = ring;
    op_reset = 1'b1;
    op(OP_CTR, 8'd3, 1'b0);
    op_reset = 1'b0;
    chk(res_data, 16'h0000);
    chk({15'h0, res_coil}, 16'h0000);
    for (i = 1; i <= 4; i++) begin
      op(OP_CTR, 8'd3, 1'b0);
      op(OP_CTR, 8'd3, 1'b1);
      chk(res_data, (i < 4) ? 16'(i) : (ring ? 16'h0000 : 16'h0003));
      chk({15'h0, res_coil}, {15'h0, i == 3 || (i == 4 && !ring)});
    end
    op(OP_CTR, 8'd3, 1'b1);
    chk(res_data, ring ? 16'h0000 : 16'h0003);
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    chk(16'h0000, 16'h0001);
    end_sim();
  end

  initial begin
    int i;
    logic [15:0] b, c, w;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    chk({13'h0, res_valid, res_coil, alarm}, 16'h0000);
    scan(1'b1);
    scan(1'b0);
    op(OP_TMR_BASE, 8'd5, 1'b0);
    chk({15'h0, alarm}, 16'h0000);
    op(OP_TMR_VAR, 8'd5, 1'b0);
    chk({15'h0, alarm}, 16'h0001);
    scan(1'b1);
    chk({15'h0, alarm}, 16'h0000);
    scan(1'b0);
    op(OP_CTR, 8'd128, 1'b1);
    chk({14'h0, res_coil, alarm}, 16'h0001);
    scan(1'b1);
    scan(1'b0);
    scan(1'b0);
    done("numbering");
    tick_select = 3'h5;
    first_operand = 16'h0005;
    op(OP_TMR_VAR, 8'd1, 1'b1);
    chk({15'h0, res_coil}, 16'h0000);
    scan(1'b0);
    op(OP_TMR_VAR, 8'd1, 1'b1);
    scan(1'b0);
    op(OP_TMR_VAR, 8'd1, 1'b1);
    chk({15'h0, res_coil}, 16'h0001);
    op(OP_TMR_VAR, 8'd1, 1'b0);
    chk({res_coil, res_data[14:0]}, 16'h0000);
    tick_select = 3'h4;
    first_operand = 16'h0001;
    scan(1'b0);
    op(OP_TMR_VAR, 8'd1, 1'b1);
    chk({15'h0, res_coil}, 16'h0000);
    done("timer");
    first_operand = 16'h0003;
    count_run(1'b0);
    count_run(1'b1);
    first_number_select = 1'b1;
    count_direction = 1'b1;
    op_reset = 1'b1;
    op(OP_CTR, 8'd3, 1'b0);
    op_reset = 1'b0;
    chk(res_data, 16'h0001);
    op(OP_CTR, 8'd3, 1'b1);
    chk(res_data, 16'h0003);
    op(OP_CTR, 8'd3, 1'b0);
    op(OP_CTR, 8'd3, 1'b1);
    chk(res_data, 16'h0002);
    scan(1'b1);
    op(OP_CTR, 8'd3, 1'b0);
    chk(res_data, 16'h0000);
    scan(1'b0);
    done("counter");
    for (i = 0; i < 40; i++) begin
      w = (i % 2) ? 16'h0002 : 16'h0001;
      b = (i % 2) ? (16'($random(seed)) & 16'h7fff) : 16'($unsigned($random(seed)) % 200);
      c = b + 16'($unsigned($random(seed)) % 20);
      op_len = w;
      first_operand = c;
      second_operand = b;
      op(OP_DEC, 8'd0, 1'b1);
      chk(res_data, dec_exp(c, b, w));
    end
    op_len = 16'h0001;
    first_operand = 16'h0042;
    second_operand = 16'h0042;
    op(OP_DEC, 8'd0, 1'b1);
    chk(res_data, 16'h0001);
    op(OP_DEC, 8'd0, 1'b0);
    chk(res_data, 16'h0000);
    done("decoder");
    for (i = 0; i < 32; i++) begin
      c = 16'($random(seed));
      mem[16 + i] = c[7:0];
      tbl_put(9'(16 + i), c[7:0]);
    end
    second_operand = 16'h0010;
    goal_operand = 16'h0004;
    for (i = 0; i < 10; i++) begin
      w = (i < 5) ? 16'h0001 : 16'h0002;
      op_len = w;
      first_operand = 16'(i % 5);
      b = 16'h0010 + w * first_operand;
      op(OP_COD, 8'd2, 1'b1);
      chk({15'h0, res_coil}, {15'h0, i >= 4});
      if (i % 5 != 4) chk(res_data, (i < 5) ? {8'h00, mem[b]} : {mem[b + 1], mem[b]});
    end
    op_reset = 1'b1;
    op(OP_COD, 8'd2, 1'b0);
    op_reset = 1'b0;
    chk({15'h0, res_coil}, 16'h0000);
    first_operand = 16'h0000;
    second_operand = 16'h01fe;
    op(OP_COD, 8'd2, 1'b1);
    chk({15'h0, res_coil}, 16'h0001);
    goal_operand = 16'd101;
    second_operand = 16'h0000;
    op(OP_GATE, 8'd0, 1'b0);
    op(OP_COD, 8'd2, 1'b1);
    chk({15'h0, res_coil}, 16'h0000);
    op(OP_GATE_END, 8'd0, 1'b1);
    op(OP_COD, 8'd2, 1'b1);
    chk({15'h0, res_coil}, 16'h0001);
    chk({15'h0, alarm}, 16'h0000);
    done("converter and gate");
    first_operand = 16'd12;
    for (i = 0; i < 7; i++) begin
      first_number_select = (i < 6);
      second_operand = (i < 6) ? 16'h0001 : 16'h0005;
      goal_operand = 16'(rg[i]);
      short_path = (i != 4 && i != 6);
      preceding_pos = (i < 4 || i == 6);
      step_output = (i == 4 || i == 5);
      op(OP_ROT, 8'd0, 1'b1);
      chk(res_data, 16'(rr[i]));
      chk({15'h0, res_coil}, 16'(rc[i]));
    end
    goal_operand = 16'h0004;
    op(OP_ROT, 8'd0, 1'b0);
    chk({res_coil, res_data[14:0]}, 16'h000b);
    op(OP_GATE, 8'd0, 1'b1);
    op(OP_FLOW, 8'd0, 1'b0);
    chk({15'h0, alarm}, 16'h0001);
    scan(1'b1);
    chk({15'h0, alarm}, 16'h0000);
    op(OP_GATE, 8'd0, 1'b1);
    scan(1'b0);
    chk({15'h0, alarm}, 16'h0001);
    done("indexer and alarms");
    end_sim();
  end
endmodule
`default_nettype wire
